/* hdl/tpe_defs.svh */
// constants for the transmit phase fifo and 8b/10b encoder
// assumes inclusion by bare name from the package and the design file
`ifndef TPE_DEFS_SVH
`define TPE_DEFS_SVH
// channel geometry
`define TPE_CH_WIDTH 16
`define TPE_NUM_CH 1
`define TPE_LANES 2
`define TPE_FIFO_DEPTH 4
`define TPE_FIFO_WIDTH 22
// register offsets
`define TPE_CTRL_OFS 8'h00
`define TPE_STAT_OFS 8'h04
// control register fields and reset value
`define TPE_CTRL_RST 32'h0000_0001
`define TPE_EN_BIT 0
`define TPE_SLIP_LSB 8
`define TPE_SLIP_MSB 12
`define TPE_SLIP_MAX 5'h13
// status register fields
`define TPE_ST_EMPTY 0
`define TPE_ST_FULL 1
`define TPE_ST_ERR 2
`define TPE_ST_RD 3
`define TPE_ST_LVL_LSB 4
`define TPE_ST_LVL_MSB 6
`endif

/* hdl/tpe_pkg.sv */
// types shared by the encoder and its test bench
// assumes tpe_defs.svh is on the include path
package tpe_pkg;
  `include "tpe_defs.svh"
  // parallel word from the fabric: channel width times channels
  typedef logic [`TPE_CH_WIDTH*`TPE_NUM_CH-1:0] tpe_data_type;
  typedef logic [`TPE_LANES-1:0] tpe_lane_type;
  typedef logic [10*`TPE_LANES-1:0] tpe_code_type;
  // one encoded symbol and the running disparity after it
  typedef struct packed {
    logic [9:0] code;
    logic rd;
  } tpe_enc_type;
  // complete state of the top module
  typedef struct packed {
    logic en;
    logic [4:0] slip;
    logic rd;
    tpe_code_type cur;
    tpe_code_type code;
    logic vld;
    logic [31:0] rdata;
  } tpe_top_state_type;
endpackage

/* hdl/tpe_encoder.sv */
// transmit phase fifo and two-lane 8b/10b encoder with bit slip
// assumes fabric and transmit logic share i_clk (frequency locked, 0 ppm)
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "tpe_defs.svh"

// small synchronous fifo, count based, registered flags
module tpe_fifo #(
  parameter int WIDTH = 22,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // fill side
  input wire logic i_wr_valid,
  input wire logic [WIDTH-1:0] i_wr_data,
  output logic o_wr_ready,
  // drain side
  output logic o_rd_valid,
  output logic [WIDTH-1:0] o_rd_data,
  input wire logic i_rd_ready,
  // status
  output logic o_err,
  output logic [$clog2(DEPTH):0] o_level
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic rdy;
    logic vld;
    logic err;
  } tpe_fifo_state_type;
  tpe_fifo_state_type q, d;
  logic push, pop;

  // flags come from the next count, so they never lag a push or pop
  // push, pop and flag update
  always_comb begin
    d = q;
    push = i_wr_valid & q.rdy;
    pop = q.vld & i_rd_ready;
    if (push) begin
      d.mem[q.wp] = i_wr_data;
      d.wp = q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = q.rp + 1'b1;
    end
    d.cnt = q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    d.rdy = (d.cnt != FULL_CNT);
    d.vld = (d.cnt != '0);
    d.err = (d.cnt == '0) | (d.cnt == FULL_CNT);
  end

  // state register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q <= '0;
      q.rdy <= 1'b1;
      q.err <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign o_wr_ready = q.rdy;
  assign o_rd_valid = q.vld;
  assign o_rd_data = q.mem[q.rp];
  assign o_err = q.err;
  assign o_level = q.cnt;
endmodule

// Summary of operation
// - optional fabric write clock must be frequency locked, zero ppm, to transmit clock
// - parallel input is channel width times channel count bits wide
// - fifo error output is high while the phase fifo is full or empty
// - bonded setups clock fifo read and write from the shared clock unit
// - unbonded channels each provide their own fabric interface clock
// - transmitted stream is slipped by the selected number of bits; the code clamps a selection above 19 to 19
// - control-select high sends a K group, low sends a D group
// - control-select has one bit per byte lane
// - forced disparity: value high starts negative, low starts positive
// - disparity value has one bit per byte lane
// - force bit low follows normal running disparity, one bit per lane
module tpe_encoder (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // fabric word stream
  input wire tpe_pkg::tpe_data_type i_tx_data,
  input wire tpe_pkg::tpe_lane_type i_ctrl_sel,
  input wire tpe_pkg::tpe_lane_type i_force_disp,
  input wire tpe_pkg::tpe_lane_type i_disp_val,
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  // encoded stream, lane 0 in the upper ten bits
  output tpe_pkg::tpe_code_type o_tx_code,
  output logic o_tx_code_valid,
  output logic o_fifo_err,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata
);
  import tpe_pkg::*;

  // 5b/6b and 3b/4b codes for negative disparity, a / f leftmost
  localparam logic [191:0] SIX_TBL = {
    6'b101011, 6'b011110, 6'b101110, 6'b001110, 6'b110110, 6'b010110, 6'b100110, 6'b110011,
    6'b111010, 6'b011010, 6'b101010, 6'b001011, 6'b110010, 6'b010011, 6'b100011, 6'b011011,
    6'b010111, 6'b011100, 6'b101100, 6'b001101, 6'b110100, 6'b010101, 6'b100101, 6'b111001,
    6'b111000, 6'b011001, 6'b101001, 6'b110101, 6'b110001, 6'b101101, 6'b011101, 6'b100111};
  localparam logic [31:0] FOUR_TBL = {
    4'b1110, 4'b0110, 4'b1010, 4'b1101, 4'b1100, 4'b0101, 4'b1001, 4'b1011};
  localparam int FW = `TPE_FIFO_WIDTH;
  localparam int CW = 10 * `TPE_LANES;

  // only K28.x and the Kx.7 groups are valid control codes
  // encode one byte; rd high means positive running disparity
  function automatic tpe_enc_type enc_byte(input logic [7:0] b, input logic k, input logic rd);
    tpe_enc_type r;
    logic [5:0] six;
    logic [3:0] four;
    logic rd6, bal6, bal4, alt, k28, flip;
    k28 = k && (b[4:0] == 5'h1c);
    six = k28 ? 6'b001111 : SIX_TBL[b[4:0]*6 +: 6];
    bal6 = ($countones(six) == 3);
    if (rd && (!bal6 || six == 6'b111000)) begin
      six = ~six;
    end
    rd6 = bal6 ? rd : ~rd;
    alt = (b[7:5] == 3'h7) && (k ||
          (!rd6 && (b[4:0] == 5'h11 || b[4:0] == 5'h12 || b[4:0] == 5'h14)) ||
          (rd6 && (b[4:0] == 5'h0b || b[4:0] == 5'h0d || b[4:0] == 5'h0e)));
    four = alt ? 4'b0111 : FOUR_TBL[b[7:5]*4 +: 4];
    bal4 = ($countones(four) == 2);
    if (k28 && bal4 && four != 4'b1100) begin
      flip = !rd6;
    end else begin
      flip = rd6 && (!bal4 || four == 4'b1100);
    end
    r.code = {six, flip ? ~four : four};
    r.rd = bal4 ? rd6 : ~rd6;
    return r;
  endfunction

  tpe_top_state_type q, d;
  logic [FW-1:0] fifo_out;
  logic fifo_vld, fifo_err, fifo_rdy, pop;
  logic [2:0] fifo_lvl;
  tpe_enc_type enc0, enc1;
  logic rd0_in, rd1_in;
  logic [2*CW-1:0] win;
  tpe_data_type pop_data;
  tpe_lane_type pop_ctrl, pop_force, pop_val;
  tpe_code_type cur_grp;
  localparam logic [31:0] CTRL_RST = `TPE_CTRL_RST;

  // fifo read and write on one clock
  // i_clk is this channel's interface clock
  // word width and per-lane flag bits
  tpe_fifo #(.WIDTH(FW), .DEPTH(`TPE_FIFO_DEPTH)) u_fifo (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_wr_valid(i_tx_valid),
    .i_wr_data({i_disp_val, i_force_disp, i_ctrl_sel, i_tx_data}),
    .o_wr_ready(fifo_rdy),
    .o_rd_valid(fifo_vld),
    .o_rd_data(fifo_out),
    .i_rd_ready(q.en),
    .o_err(fifo_err),
    .o_level(fifo_lvl)
  );

  // unpack the word leaving the fifo
  assign {pop_val, pop_force, pop_ctrl, pop_data} = fifo_out;
  assign pop = fifo_vld & q.en;

  assign rd0_in = pop_force[0] ? ~pop_val[0] : q.rd;
  assign rd1_in = pop_force[1] ? ~pop_val[1] : enc0.rd;
  // K or D group per control bit
  assign enc0 = enc_byte(pop_data[7:0], pop_ctrl[0], rd0_in);
  assign enc1 = enc_byte(pop_data[15:8], pop_ctrl[1], rd1_in);

  // both groups of the popped word, lane 0 first
  assign cur_grp = {enc0.code, enc1.code};
  // slip window: older word above newer
  assign win = {q.cur, cur_grp};

  // next state: encoder, slip and register port
  always_comb begin
    d = q;
    d.vld = 1'b0;
    d.rdata = 32'h0000_0000;
    // one group per byte, disparity carried
    if (pop) begin
      d.cur = cur_grp;
      d.rd = enc1.rd;
      d.vld = 1'b1;
    end
    // delay the stream by the slip count
    if (pop) begin
      d.code = win[q.slip +: CW];
    end
    if (i_wr && i_addr == `TPE_CTRL_OFS) begin
      d.en = i_wdata[`TPE_EN_BIT];
      if (i_wdata[`TPE_SLIP_MSB:`TPE_SLIP_LSB] > `TPE_SLIP_MAX) begin
        d.slip = `TPE_SLIP_MAX;
      end else begin
        d.slip = i_wdata[`TPE_SLIP_MSB:`TPE_SLIP_LSB];
      end
    end
    if (i_rd) begin
      if (i_addr == `TPE_CTRL_OFS) begin
        d.rdata[`TPE_EN_BIT] = q.en;
        d.rdata[`TPE_SLIP_MSB:`TPE_SLIP_LSB] = q.slip;
      end else if (i_addr == `TPE_STAT_OFS) begin
        d.rdata[`TPE_ST_EMPTY] = ~fifo_vld;
        d.rdata[`TPE_ST_FULL] = ~fifo_rdy;
        d.rdata[`TPE_ST_ERR] = fifo_err;
        d.rdata[`TPE_ST_RD] = q.rd;
        d.rdata[`TPE_ST_LVL_MSB:`TPE_ST_LVL_LSB] = fifo_lvl;
      end
    end
  end

  // state register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q <= '0;
      q.en <= CTRL_RST[`TPE_EN_BIT];
    end else begin
      q <= d;
    end
  end

  // outputs
  assign o_tx_ready = fifo_rdy;
  assign o_tx_code = q.code;
  assign o_tx_code_valid = q.vld;
  assign o_fifo_err = fifo_err;
  assign o_rdata = q.rdata;

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  fifo_err_level_a: assert property (o_fifo_err == (fifo_lvl == 3'h0 || fifo_lvl == 3'h4))
    else $error("fifo error flag does not match level");
  fifo_no_over_a: assert property (fifo_lvl == 3'h4 |-> !o_tx_ready ##1 fifo_lvl <= 3'h4)
    else $error("fifo accepts while full");
  group_per_pop_a: assert property (pop |=> o_tx_code_valid)
    else $error("no code group after pop");
  idle_no_code_a: assert property (!pop |=> !o_tx_code_valid)
    else $error("code group without pop");
  comma_k_code_a: assert property (pop && pop_ctrl[0] && pop_data[7:0] == 8'hbc
      |=> q.cur[19:10] == 10'b0011111010 || q.cur[19:10] == 10'b1100000101)
    else $error("control byte not sent as K28.5");
  data_zero_a: assert property (pop && !pop_ctrl[0] && pop_data[7:0] == 8'h00
      |=> q.cur[19:10] == 10'b1001110100 || q.cur[19:10] == 10'b0110001011)
    else $error("data byte not sent as D0.0");
  force_neg_a: assert property (pop && pop_force[0] && pop_val[0] && !pop_ctrl[0]
      && pop_data[7:0] == 8'h00 |=> q.cur[19:10] == 10'b1001110100)
    else $error("forced negative start ignored");
  force_pos_a: assert property (pop && pop_force[0] && !pop_val[0] && !pop_ctrl[0]
      && pop_data[7:0] == 8'h00 |=> q.cur[19:10] == 10'b0110001011)
    else $error("forced positive start ignored");
  rd_track_a: assert property (pop && pop_force == 2'b00 && !pop_ctrl[0] && pop_data[7:0] == 8'h00
      && $past(pop) |-> enc0.code == ($past(enc1.rd) ? 10'b0110001011 : 10'b1001110100))
    else $error("running disparity not carried");
  slip_zero_a: assert property (q.slip == 5'h00 && pop |=> o_tx_code == q.cur)
    else $error("zero slip alters stream");

  force_lane1_a: assert property (pop && pop_force[1] && pop_val[1] && !pop_ctrl[1]
      && pop_data[15:8] == 8'h00 |=> q.cur[9:0] == 10'b1001110100)
    else $error("forced negative start ignored on lane 1");
  ready_not_full_a: assert property (o_tx_ready == (fifo_lvl != 3'h4))
    else $error("ready does not track fifo level");
  rd_held_idle_a: assert property (!pop |=> $stable(q.rd))
    else $error("running disparity moved without a pop");
  slip_clamp_a: assert property (q.slip <= `TPE_SLIP_MAX)
    else $error("slip count above its limit");
  stat_err_read_a: assert property (i_rd && i_addr == `TPE_STAT_OFS
      |=> o_rdata[`TPE_ST_ERR] == $past(fifo_err))
    else $error("status error bit does not match fifo flag");

  cov_full_c: cover property (fifo_lvl == 3'h4 ##1 pop);
  cov_forced_c: cover property (pop && pop_force != 2'b00);
  cov_k_c: cover property (pop && pop_ctrl == 2'b11);
  cov_slip_c: cover property (q.slip != 5'h00 && pop ##1 pop);
  cov_comma_c: cover property (pop && pop_ctrl[0] && pop_data[7:0] == 8'hbc);
endmodule

/* dv/tpe_fabric_model.sv */
// fabric source model: offers random words, holds each until ready
// assumes the bench seeds $urandom once and paces the model with i_go
`timescale 1ns/1ps
module tpe_fabric_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // pacing and handshake
  input wire logic i_go,
  input wire logic i_ready,
  output logic o_valid,
  // word and per-lane flags
  output logic [15:0] o_data,
  output logic [1:0] o_ctrl,
  output logic [1:0] o_force,
  output logic [1:0] o_disp
);
  logic [31:0] c;
  logic [31:0] d;
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_valid <= 1'b0;
      o_data <= 16'h0000;
      o_ctrl <= 2'h0;
      o_force <= 2'h0;
      o_disp <= 2'h0;
    end else if (!o_valid || i_ready) begin
      c = $urandom;
      d = $urandom;
      if (i_go && c[7:6] != 2'h0) begin
        o_valid <= 1'b1;
        o_ctrl <= c[1:0];
        o_force <= c[3:2] & c[5:4];
        o_disp <= c[9:8];
        // control lanes carry only K28 bytes
        o_data[7:0] <= c[0] ? {d[2:0], 5'h1c} : d[7:0];
        o_data[15:8] <= c[1] ? {d[10:8], 5'h1c} : d[15:8];
      end else begin
        // released lines invert the data each idle cycle, so the old word returns every second one
        o_valid <= 1'b0;
        o_data <= ~o_data;
      end
    end
  end
endmodule

/* dv/tpe_encoder_test.sv */
// self-checking bench for the transmit fifo and 8b/10b encoder
// assumes a single 100 MHz clock and the fabric model on the word side
`timescale 1ns/1ps
module tpe_encoder_test;
  import tpe_pkg::*;
  logic i_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, go = 1'b0, rd = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0, rdv, o_rdata;
  tpe_data_type i_tx_data;
  tpe_lane_type i_ctrl_sel, i_force_disp, i_disp_val;
  logic i_tx_valid, o_tx_ready, o_tx_code_valid, o_fifo_err;
  tpe_code_type o_tx_code, prev, cur;
  int bad_count = 0, comparisons = 0, cyc = 0, acc = 0, a0 = 0, slip = 0, e = 0;
  int sl[3] = '{1, 9, 31};
  tpe_code_type q[$];
  localparam logic [5:0] T6 [32] = '{6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17, 6'h1b, 6'h23, 6'h13, 6'h32,
    6'h0b, 6'h2a, 6'h1a, 6'h3a, 6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
  localparam logic [3:0] T4 [8] = '{4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};

  tpe_encoder tpe_encoder_inst (.i_clk(i_clk), .i_rst(i_rst), .i_tx_data(i_tx_data),
    .i_ctrl_sel(i_ctrl_sel), .i_force_disp(i_force_disp), .i_disp_val(i_disp_val),
    .i_tx_valid(i_tx_valid), .o_tx_ready(o_tx_ready), .o_tx_code(o_tx_code),
    .o_tx_code_valid(o_tx_code_valid), .o_fifo_err(o_fifo_err), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata));
  tpe_fabric_model tpe_fabric_model_inst (.i_clk(i_clk), .i_rst(i_rst), .i_go(go),
    .i_ready(o_tx_ready), .o_valid(i_tx_valid), .o_data(i_tx_data), .o_ctrl(i_ctrl_sel),
    .o_force(i_force_disp), .o_disp(i_disp_val));

  // clock generator
  initial begin
    forever #5 i_clk = ~i_clk;
  end

  // one byte to {group, ending disparity}; r is 1 for positive
  function automatic logic [10:0] enc(input logic [7:0] b, input logic k, input logic r);
    logic [5:0] s;
    logic [3:0] f;
    s = k ? 6'h0f : T6[b[4:0]];
    if (r && ($countones(s) != 3 || s == 6'h38)) s = ~s;
    r = r ^ ($countones(s) != 3);
    f = T4[b[7:5]];
    if (b[7:5] == 3'h7 && (k || (!r && b[4:0] inside {17, 18, 20})
        || (r && b[4:0] inside {11, 13, 14}))) f = 4'h7;
    if (k && b[7:5] inside {1, 2, 5, 6}) f = ~f;
    if (r && ($countones(f) != 2 || f == 4'hc || k)) f = ~f;
    return {s, f, r ^ ($countones(f) != 2)};
  endfunction

  task automatic check(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask

  // stop feeding, wait for the queue to empty, expect an empty fifo
  task automatic drain(input string m);
    go <= 1'b0;
    for (int i = 0; i < 200 && (i_tx_valid || q.size() != 0); i++) begin
      @(posedge i_clk);
      #1;
    end
    repeat (3) @(posedge i_clk);
    #1 check(o_fifo_err === 1'b1 && q.size() == 0, "stream did not drain");
    reg_rd(8'h04, rdv);
    check(rdv === {25'h0, 3'h0, rd, 3'h5}, "status after drain");
    $display("test %s done", m);
  endtask

  task automatic final_report;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // expected groups built per taken word, compared per pop
  always @(posedge i_clk) begin
    logic [10:0] e0, e1;
    if (i_rst) begin
      q.delete();
      prev = '0;
      rd = 1'b0;
    end else begin
      if (o_tx_code_valid) begin
        cur = (q.size() != 0) ? q.pop_front() : 'x;
        check(o_tx_code === 20'({prev, cur} >> slip), "code mismatch");
        prev = cur;
      end
      if (i_tx_valid && o_tx_ready) begin
        e0 = enc(i_tx_data[7:0], i_ctrl_sel[0], i_force_disp[0] ? !i_disp_val[0] : rd);
        e1 = enc(i_tx_data[15:8], i_ctrl_sel[1], i_force_disp[1] ? !i_disp_val[1] : e0[0]);
        rd = e1[0];
        q.push_back({e0[10:1], e1[10:1]});
        acc++;
      end
    end
  end

  // cycle ceiling against hangs
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 8000) begin
      bad_count++;
      final_report();
    end
  end

  initial begin
    void'($urandom(32'h90f0));
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    reg_rd(8'h00, rdv);
    check(rdv === 32'h0000_0001, "ctrl reset value");
    reg_rd(8'h04, rdv);
    check(rdv === 32'h0000_0005, "status reset value");
    @(posedge i_clk);
    #1 check(o_rdata === 32'h0, "read data not cleared");
    reg_wr(8'h20, 32'hffff_ffff);
    reg_rd(8'h20, rdv);
    check(rdv === 32'h0, "unmapped read");
    reg_rd(8'h00, rdv);
    check(rdv === 32'h0000_0001, "unmapped write leaked");
    $display("test registers done");
    go <= 1'b1;
    repeat (400) @(posedge i_clk);
    drain("random stream");
    // slip values, the last one above the clamp
    foreach (sl[i]) begin
      e = (sl[i] > 19) ? 19 : sl[i];
      reg_wr(8'h00, 32'(sl[i] << 8) | 32'h1);
      reg_rd(8'h00, rdv);
      check(rdv === (32'(e << 8) | 32'h1), "slip readback");
      slip = e;
      go <= 1'b1;
      repeat (150) @(posedge i_clk);
      drain("slip");
    end
    // disabled encoder: fill until refused, then release
    reg_wr(8'h00, 32'(slip << 8));
    a0 = acc;
    go <= 1'b1;
    repeat (12) begin
      @(posedge i_clk);
      #1 check(o_fifo_err === (acc - a0 == 0 || acc - a0 == 4), "fifo error flag");
      check(o_tx_ready === (acc - a0 < 4), "ready while filling");
    end
    reg_rd(8'h04, rdv);
    check((rdv & 32'h77) === 32'h46, "status when full");
    reg_wr(8'h00, 32'(slip << 8) | 32'h1);
    drain("fill and drain");
    final_report();
  end
endmodule
